// ==== verilog/operand_access.sv ====
// Purpose: digit-field and indexed operand access on the shared I/O register area
// Assumes: one instruction or one scan at a time, started from idle
// Notes:   transfer and exchange act on the area; scan maps it onto modules
//
// How it works
// - signed 16-bit index added to base address
// - out-of-range index: skip, set both error relays
// - width codes 0-4: 1 bit or 1-4 digits
// - width codes 5 to 15 are rejected
// - spanning fields gathered low to high address
// - digit designation only on transfer or exchange
// - source field zero-extended into 16 bits
// - destination field takes source low digits
// - both operands may be digit designated
// - exchange swaps field and word low digits
// - field beyond range: excess ignored, error raised
// - index offsets the designated start bit
// - one shared area of 64 16-bit words
// - sixteen addressable bits per register
// - direction of each word follows module allocation
// - scan reads inputs, drives outputs from registers
`timescale 1ns/1ps
module operand_access
	import opnd_pkg::*;
(
	// clock and reset
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_n_i,
	// instruction request
	input  wire logic                                 start_i,
	input  wire opnd_pkg::op_t                        op_i,
	// source operand
	input  wire logic [opnd_pkg::WADDR_W-1:0]         src_word_i,
	input  wire logic [opnd_pkg::BIT_POS_W-1:0]       src_bit_i,
	input  wire logic                                 src_digit_en_i,
	input  wire logic [3:0]                           src_code_i,
	input  wire logic                                 src_index_en_i,
	input  wire logic signed [opnd_pkg::IDX_W-1:0]    src_index_i,
	// destination operand
	input  wire logic [opnd_pkg::WADDR_W-1:0]         dst_word_i,
	input  wire logic [opnd_pkg::BIT_POS_W-1:0]       dst_bit_i,
	input  wire logic                                 dst_digit_en_i,
	input  wire logic [3:0]                           dst_code_i,
	input  wire logic                                 dst_index_en_i,
	input  wire logic signed [opnd_pkg::IDX_W-1:0]    dst_index_i,
	// boundary error relays
	input  wire logic                                 err_clear_i,
	output logic                                      bound_err_a_o,
	output logic                                      bound_err_b_o,
	// instruction status
	output logic                                      done_o,
	output logic                                      rejected_o,
	output logic [opnd_pkg::WORD_W-1:0]               src_value_o,
	// scan with mounted modules
	input  wire logic                                 scan_i,
	input  wire logic [opnd_pkg::IO_WORDS-1:0]        io_is_input_i,
	input  wire logic [opnd_pkg::IO_WORDS*opnd_pkg::WORD_W-1:0] in_words_i,
	output logic [opnd_pkg::IO_WORDS*opnd_pkg::WORD_W-1:0]      out_words_o,
	output logic                                      scan_done_o
);
	import opnd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// storage and latched request

	logic [WORD_W-1:0]    area_reg [IO_WORDS];
	state_t               state_reg;
	op_t                  op_reg;
	logic [WADDR_W-1:0]   sw_reg, dw_reg;
	logic [BIT_POS_W-1:0] sb_reg, db_reg;
	logic                 sd_reg, dd_reg, si_reg, di_reg;
	logic [3:0]           sc_reg, dc_reg;
	logic signed [IDX_W-1:0] sx_reg, dx_reg;

	logic [WADDR_W-1:0]   s_word, d_word;
	logic [BIT_POS_W-1:0] s_bit, d_bit;
	logic [4:0]           s_width, d_width;
	logic                 s_code_ok, d_code_ok, s_start_ok, d_start_ok, s_part, d_part;
	logic [WORD_W-1:0]    s_val, d_val;
	logic                 reject, skip, execute, bound_hit;

	// read a field; the word past the area reads as zero, so excess drops out
	function automatic logic [WORD_W-1:0] get_field(input logic [WADDR_W-1:0] w,
			input logic [BIT_POS_W-1:0] b, input logic [4:0] width,
			input logic [WORD_W-1:0] lo, input logic [WORD_W-1:0] hi);
		logic [2*WORD_W-1:0] pair;
		logic [2*WORD_W-1:0] mask;
		pair = {((32'(w) + 32'd1) < 32'(IO_WORDS)) ? hi : WORD_RST, lo} >> b;
		mask = (32'h1 << width) - 32'h1;
		return WORD_W'(pair & mask);
	endfunction

	// merge low bits of val into one word of the area at a field position
	function automatic logic [WORD_W-1:0] put_field(input logic [WORD_W-1:0] cur,
			input int idx, input logic [WADDR_W-1:0] w, input logic [BIT_POS_W-1:0] b,
			input logic [4:0] width, input logic [WORD_W-1:0] val);
		logic [2*WORD_W-1:0] mask;
		logic [2*WORD_W-1:0] data;
		logic [WORD_W-1:0]   res;
		mask = ((32'h1 << width) - 32'h1) << b;
		data = (32'(val) << b) & mask;
		res  = cur;
		if (idx == int'(w)) begin
			res = (cur & ~mask[WORD_W-1:0]) | data[WORD_W-1:0];
		end else if (idx == int'(w) + 1) begin
			res = (cur & ~mask[2*WORD_W-1:WORD_W]) | data[2*WORD_W-1:WORD_W];
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// operand resolution

	field_locate u_src (
		.base_word_i (sw_reg),
		.base_bit_i  (sb_reg),
		.digit_en_i  (sd_reg),
		.code_i      (sc_reg),
		.index_en_i  (si_reg),
		.index_i     (sx_reg),
		.ea_word_o   (s_word),
		.ea_bit_o    (s_bit),
		.width_o     (s_width),
		.code_ok_o   (s_code_ok),
		.start_ok_o  (s_start_ok),
		.partial_o   (s_part)
	);

	field_locate u_dst (
		.base_word_i (dw_reg),
		.base_bit_i  (db_reg),
		.digit_en_i  (dd_reg),
		.code_i      (dc_reg),
		.index_en_i  (di_reg),
		.index_i     (dx_reg),
		.ea_word_o   (d_word),
		.ea_bit_o    (d_bit),
		.width_o     (d_width),
		.code_ok_o   (d_code_ok),
		.start_ok_o  (d_start_ok),
		.partial_o   (d_part)
	);

	// decide what the latched instruction may do
	always_comb begin
		s_val   = get_field(s_word, s_bit, s_width, area_reg[s_word],
			area_reg[(32'(s_word) + 32'd1) < 32'(IO_WORDS) ? WADDR_W'(s_word + 6'h01) : s_word]);
		d_val   = get_field(d_word, d_bit, d_width, area_reg[d_word],
			area_reg[(32'(d_word) + 32'd1) < 32'(IO_WORDS) ? WADDR_W'(d_word + 6'h01) : d_word]);
		reject  = !s_code_ok || !d_code_ok || ((sd_reg || dd_reg) && (op_reg == other_op));
		skip    = !s_start_ok || !d_start_ok;
		execute = (state_reg == st_exec) && !reject && !skip && (op_reg != other_op);
		bound_hit = (state_reg == st_exec) && !reject && (skip || s_part || d_part);
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing

	// one cycle per instruction or scan keeps the two from ever overlapping
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= st_idle;
		end else begin
			case (state_reg)
				st_idle: begin
					if (start_i) begin
						state_reg <= st_exec;
					end else if (scan_i) begin
						state_reg <= st_scan;
					end
				end
				st_exec: state_reg <= st_idle;
				st_scan: state_reg <= st_idle;
				default: state_reg <= st_idle;
			endcase
		end
	end

	// request latch, taken only while idle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_reg <= other_op;
			{sw_reg, sb_reg, sd_reg, sc_reg, si_reg, sx_reg} <= '0;
			{dw_reg, db_reg, dd_reg, dc_reg, di_reg, dx_reg} <= '0;
		end else if (state_reg == st_idle && start_i) begin
			op_reg <= op_i;
			{sw_reg, sb_reg, sd_reg, sc_reg, si_reg, sx_reg} <=
				{src_word_i, src_bit_i, src_digit_en_i, src_code_i, src_index_en_i, src_index_i};
			{dw_reg, db_reg, dd_reg, dc_reg, di_reg, dx_reg} <=
				{dst_word_i, dst_bit_i, dst_digit_en_i, dst_code_i, dst_index_en_i, dst_index_i};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared area writes

	// exchange uses values read before the edge, so both moves are simultaneous
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < IO_WORDS; i++) begin
				area_reg[i] <= WORD_RST;
			end
		end else if (execute) begin
			for (int i = 0; i < IO_WORDS; i++) begin
				// destination merge goes last, so it wins where the two fields meet
				area_reg[i] <= put_field((op_reg == exchange_op) ?
					put_field(area_reg[i], i, s_word, s_bit, s_width, d_val) : area_reg[i],
					i, d_word, d_bit, d_width, s_val);
			end
		end else if (state_reg == st_scan) begin
			for (int i = 0; i < IO_WORDS; i++) begin
				if (io_is_input_i[i]) begin
					area_reg[i] <= in_words_i[i*WORD_W +: WORD_W];
				end
			end
		end
	end

	// output modules only see words allocated as outputs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_words_o <= '0;
		end else if (state_reg == st_scan) begin
			for (int i = 0; i < IO_WORDS; i++) begin
				out_words_o[i*WORD_W +: WORD_W] <= io_is_input_i[i] ? WORD_RST : area_reg[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status

	// relays are sticky; a new error wins over a clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bound_err_a_o <= 1'b0;
			bound_err_b_o <= 1'b0;
		end else if (bound_hit) begin
			bound_err_a_o <= 1'b1;
			bound_err_b_o <= 1'b1;
		end else if (err_clear_i) begin
			bound_err_a_o <= 1'b0;
			bound_err_b_o <= 1'b0;
		end
	end

	// completion pulses and the source field as read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_o      <= 1'b0;
			rejected_o  <= 1'b0;
			scan_done_o <= 1'b0;
			src_value_o <= WORD_RST;
		end else begin
			done_o      <= (state_reg == st_exec);
			rejected_o  <= (state_reg == st_exec) && reject;
			scan_done_o <= (state_reg == st_scan);
			if (state_reg == st_exec && !reject && !skip) begin
				src_value_o <= s_val;
			end
		end
	end

endmodule

// ==== verilog/opnd_pkg.sv ====
// Purpose: shared constants and types for the digit-field operand access block
// Assumes: one 25 MHz clock, 64-word shared input/output register area
// Notes:   bit addresses are word number times 16 plus bit position
package opnd_pkg;

	// shared register area
	localparam int IO_WORDS  = 64;
	localparam int WORD_W    = 16;
	localparam int BIT_POS_W = 4;
	localparam int WADDR_W   = 6;
	localparam int IDX_W     = 16;
	localparam int EA_W      = 24;
	localparam int DIGIT_W   = 4;
	localparam int AREA_BITS = IO_WORDS * WORD_W;

	// field width codes
	localparam logic [3:0] single_bit_field_code = 4'h0;
	localparam logic [3:0] four_digit_field_code = 4'h4;

	// reset values
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

	typedef enum logic [1:0] {
		transfer_op = 2'h0,
		exchange_op = 2'h1,
		other_op    = 2'h2
	} op_t;

	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_exec = 3'h2,
		st_scan = 3'h4
	} state_t;

	// field width in bits for a width code; codes above 4 give zero
	function automatic logic [4:0] field_width(input logic [3:0] code);
		logic [4:0] w;
		w = 5'h00;
		if (code == single_bit_field_code) begin
			w = 5'h01;
		end else if (code <= four_digit_field_code) begin
			w = 5'(code * DIGIT_W);
		end
		return w;
	endfunction

endpackage

// ==== verilog/field_locate.sv ====
// Purpose: resolve one operand into an effective bit address and field width
// Assumes: base address and index taken from registered operand fields
// Notes:   purely combinational; instantiated once per operand
`timescale 1ns/1ps
module field_locate
	import opnd_pkg::*;
(
	// operand description
	input  wire logic [opnd_pkg::WADDR_W-1:0]   base_word_i,
	input  wire logic [opnd_pkg::BIT_POS_W-1:0] base_bit_i,
	input  wire logic                           digit_en_i,
	input  wire logic [3:0]                     code_i,
	// index register
	input  wire logic                           index_en_i,
	input  wire logic signed [opnd_pkg::IDX_W-1:0] index_i,
	// resolved operand
	output logic [opnd_pkg::WADDR_W-1:0]        ea_word_o,
	output logic [opnd_pkg::BIT_POS_W-1:0]      ea_bit_o,
	output logic [4:0]                          width_o,
	output logic                                code_ok_o,
	output logic                                start_ok_o,
	output logic                                partial_o
);
	import opnd_pkg::*;

	logic signed [EA_W-1:0] base_ea;
	logic signed [EA_W-1:0] idx_ea;
	logic signed [EA_W-1:0] ea;
	logic signed [EA_W-1:0] end_ea;

	// word operands move by whole words, digit operands by bits
	always_comb begin
		base_ea = EA_W'({base_word_i, (digit_en_i ? base_bit_i : 4'h0)});
		idx_ea  = index_en_i ? EA_W'(index_i) : '0;
		if (!digit_en_i) begin
			idx_ea = idx_ea <<< BIT_POS_W;
		end
		ea      = base_ea + idx_ea;
		width_o = digit_en_i ? field_width(code_i) : 5'(WORD_W);
		end_ea  = ea + EA_W'(width_o);
		code_ok_o  = !digit_en_i || (code_i <= four_digit_field_code);
		start_ok_o = (ea >= 0) && (ea < EA_W'(AREA_BITS));
		partial_o  = start_ok_o && (end_ea > EA_W'(AREA_BITS));
		ea_word_o  = ea[BIT_POS_W +: WADDR_W];
		ea_bit_o   = ea[BIT_POS_W-1:0];
	end

endmodule

// ==== test/operand_access_properties.sv ====
// Purpose: port checks for operand_access
// Assumes: clk_i only, rst_n_i async low
// Notes:   busy_reg tracks the one busy cycle
`timescale 1ns/1ps
module operand_access_properties
	import opnd_pkg::*;
(
	// requests
	input wire logic                          clk_i,
	input wire logic                          rst_n_i,
	input wire logic                          start_i,
	input wire opnd_pkg::op_t                 op_i,
	input wire logic                          src_digit_en_i,
	input wire logic [3:0]                    src_code_i,
	input wire logic                          scan_i,
	input wire logic [opnd_pkg::IO_WORDS-1:0] io_is_input_i,
	// results
	input wire logic                          bound_err_a_o,
	input wire logic                          bound_err_b_o,
	input wire logic                          done_o,
	input wire logic                          rejected_o,
	input wire logic                          scan_done_o,
	input wire logic [opnd_pkg::IO_WORDS*opnd_pkg::WORD_W-1:0] out_words_o
);
	logic busy_reg;
	logic leak;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// one busy cycle after any accepted request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= !busy_reg && (start_i || scan_i);
		end
	end
	// input words must never reach the output modules
	always_comb begin
		leak = 1'b0;
		for (int i = 0; i < IO_WORDS; i++) begin
			leak = leak | (io_is_input_i[i] && out_words_o[i*WORD_W +: WORD_W] != '0);
		end
	end
	sequence s_take; start_i && !busy_reg; endsequence
	sequence s_scan; scan_i && !start_i && !busy_reg; endsequence
	a_relays_equal: assert property (bound_err_a_o == bound_err_b_o)
		else $error("relays differ");
	a_done_timing: assert property (s_take |=> !done_o ##1 done_o)
		else $error("done late");
	a_done_single: assert property (done_o |=> !done_o)
		else $error("done too long");
	a_scan_timing: assert property (s_scan |=> !scan_done_o ##1 scan_done_o)
		else $error("scan late");
	a_reject_code: assert property (s_take ##0 (src_digit_en_i && src_code_i > 4'h4) |=> ##1 rejected_o && done_o)
		else $error("bad code taken");
	a_reject_other: assert property (s_take ##0 (op_i == other_op && src_digit_en_i) |=> ##1 rejected_o)
		else $error("digit on other op taken");
	a_reject_quiet: assert property (rejected_o |-> done_o && !$rose(bound_err_a_o))
		else $error("reject raised relay");
	a_relay_cause: assert property ($rose(bound_err_a_o) |-> done_o)
		else $error("relay without instruction");
	a_inputs_masked: assert property (scan_done_o |-> !leak)
		else $error("input word driven out");
endmodule

// ==== test/io_module_model.sv ====
// Purpose: mounted input and output modules
// Assumes: field data settles between scans
// Notes:   new data after every scan
`timescale 1ns/1ps
module io_module_model
	import opnd_pkg::*;
(
	// scan side
	input  wire logic                                            clk_i,
	input  wire logic                                            scan_done_i,
	input  wire logic [opnd_pkg::IO_WORDS*opnd_pkg::WORD_W-1:0] out_words_i,
	// field inputs
	output logic [opnd_pkg::IO_WORDS*opnd_pkg::WORD_W-1:0]      in_words_o
);
	int                         seed = 32'h615f;
	logic [IO_WORDS*WORD_W-1:0] loads_q;
	// racks numbered 0 to 3 outward from the basic unit, none repeated
	localparam int RACKS = 4;
	task automatic fill;
		for (int u = 0; u < RACKS; u++) begin
			for (int s = 0; s < IO_WORDS / RACKS; s++) begin
				in_words_o[(u * (IO_WORDS / RACKS) + s) * WORD_W +: WORD_W] = 16'($random(seed));
			end
		end
	endtask
	initial fill();
	// change data so a stale sample cannot match
	always @(negedge clk_i) begin
		if (scan_done_i) begin
			loads_q = out_words_i;
			fill();
		end
	end
endmodule

// ==== test/test_operand_access.sv ====
// Purpose: self-checking bench for operand_access
// Assumes: io_module_model feeds the inputs
// Notes:   area seen through scans and src_value_o
`timescale 1ns/1ps
module test_operand_access;
	import opnd_pkg::*;
	logic        clk_i = 0, rst_n_i = 0, start_i = 0, scan_i = 0, err_clear_i = 0;
	op_t         op_i = transfer_op;
	logic [5:0]  src_word_i, dst_word_i;
	logic [3:0]  src_bit_i, dst_bit_i, src_code_i, dst_code_i;
	logic        src_digit_en_i, dst_digit_en_i, src_index_en_i, dst_index_en_i;
	logic signed [15:0] src_index_i, dst_index_i;
	logic [63:0] io_is_input_i = '1;
	logic [1023:0] in_words_i, out_words_o;
	logic        bound_err_a_o, bound_err_b_o, done_o, rejected_o, scan_done_o, exp_err = 0, exp_rej;
	logic [15:0] src_value_o, exp_src = '0, area [64];
	int          seed = 32'h615f, err_total = 0, num_checks = 0;
	int          ow [2], ob [2], od [2], oc [2], oe [2], ox [2];
	operand_access uut (.clk_i, .rst_n_i, .start_i, .op_i, .src_word_i, .src_bit_i, .src_digit_en_i,
		.src_code_i, .src_index_en_i, .src_index_i, .dst_word_i, .dst_bit_i, .dst_digit_en_i, .dst_code_i,
		.dst_index_en_i, .dst_index_i, .err_clear_i, .bound_err_a_o, .bound_err_b_o, .done_o, .rejected_o,
		.src_value_o, .scan_i, .io_is_input_i, .in_words_i, .out_words_o, .scan_done_o);
	io_module_model model_io (.clk_i, .scan_done_i(scan_done_o), .out_words_i(out_words_o), .in_words_o(in_words_i));
	always #20 clk_i = ~clk_i;
	////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// bounded wait on done or scan done
	task automatic wait_for(input bit scan);
		int n;
		for (n = 0; n < 8 && (scan ? scan_done_o : done_o) !== 1'b1; n++) begin
			@(negedge clk_i);
		end
		if (n == 8) begin
			chk(16'h1, 16'h0);
			give_verdict();
		end
	endtask
	task automatic setop(input int i, w, b, d, c, e, x);
		ow[i] = w;
		ob[i] = b;
		od[i] = d;
		oc[i] = c;
		oe[i] = e;
		ox[i] = x;
	endtask
	// word operands index in words, digit operands in bits
	task automatic rnd_op(input int i, lo, span);
		int d, x;
		d = $random(seed) & 1;
		x = $random(seed) % 64;
		setop(i, lo + {$random(seed)} % span, {$random(seed)} % 16, d, {$random(seed)} % 5, $random(seed) & 1,
			d ? x : x / 16);
	endtask
	function automatic int rd(input int a, w);
		int v;
		v = 0;
		for (int k = 0; k < w && a + k < AREA_BITS; k++) v[k] = area[(a + k) / WORD_W][(a + k) % WORD_W];
		return v;
	endfunction
	task automatic wr(input int a, w, v);
		for (int k = 0; k < w && a + k < AREA_BITS; k++) area[(a + k) / WORD_W][(a + k) % WORD_W] = v[k];
	endtask
	// reference: both fields read before either is written
	task automatic model(input int o);
		int a [2], w [2], sv, dv;
		bit skip;
		bit part;
		exp_rej = 0;
		skip = 0;
		part = 0;
		for (int i = 0; i < 2; i++) begin
			w[i] = od[i] == 0 ? WORD_W : oc[i] == 0 ? 1 : oc[i] * DIGIT_W;
			a[i] = od[i] ? ow[i] * WORD_W + ob[i] + (oe[i] ? ox[i] : 0) : (ow[i] + (oe[i] ? ox[i] : 0)) * WORD_W;
			exp_rej |= od[i] && (oc[i] > 4 || o == 2);
			skip |= a[i] < 0 || a[i] >= AREA_BITS;
			part |= a[i] + w[i] > AREA_BITS;
		end
		if (exp_rej) return;
		exp_err |= skip || part;
		if (skip) return;
		sv = rd(a[0], w[0]);
		dv = rd(a[1], w[1]);
		exp_src = 16'(sv);
		// other op only checks addresses; destination is written last
		if (o == 1) wr(a[0], w[0], dv);
		if (o != 2) wr(a[1], w[1], sv);
	endtask
	task automatic exec(input int o);
		{src_word_i, src_bit_i, src_digit_en_i, src_code_i, src_index_en_i, src_index_i} =
			{6'(ow[0]), 4'(ob[0]), 1'(od[0]), 4'(oc[0]), 1'(oe[0]), 16'(ox[0])};
		{dst_word_i, dst_bit_i, dst_digit_en_i, dst_code_i, dst_index_en_i, dst_index_i} =
			{6'(ow[1]), 4'(ob[1]), 1'(od[1]), 4'(oc[1]), 1'(oe[1]), 16'(ox[1])};
		op_i = op_t'(2'(o));
		start_i = 1;
		model(o);
		@(negedge clk_i);
		start_i = 0;
		wait_for(0);
		chk(16'(rejected_o), 16'(exp_rej));
		chk(16'(bound_err_b_o), 16'(exp_err));
		chk(src_value_o, exp_src);
	endtask
	task automatic do_scan;
		logic [15:0] ex [64];
		for (int i = 0; i < 64; i++) begin
			ex[i] = io_is_input_i[i] ? 16'h0 : area[i];
			if (io_is_input_i[i]) area[i] = in_words_i[i*WORD_W +: WORD_W];
		end
		scan_i = 1;
		@(negedge clk_i);
		scan_i = 0;
		wait_for(1);
		for (int i = 0; i < 64; i++) chk(out_words_o[i*WORD_W +: WORD_W], ex[i]);
		@(negedge clk_i);
	endtask
	task automatic clr;
		err_clear_i = 1;
		@(negedge clk_i);
		err_clear_i = 0;
		exp_err = 0;
		chk(16'(bound_err_a_o), 16'h0);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk_i);
		rst_n_i = 1;
		do_scan();
		io_is_input_i = {$random(seed), $random(seed)};
		do_scan();
		for (int n = 0; n < 40; n++) begin
			rnd_op(0, 4, 23);
			rnd_op(1, 36, 24);
			exec($random(seed) & 1);
			do_scan();
		end
		clr();
		setop(1, 40, 0, 0, 0, 0, 0);
		for (int c = 5; c < 9; c++) begin
			setop(0, 5, 0, 1, c, 0, 0);
			exec(0);
		end
		setop(0, 5, 0, 1, 2, 0, 0);
		exec(2);
		setop(0, 5, 0, 0, 0, 0, 0);
		exec(2);
		setop(0, 0, 0, 0, 0, 1, -1);
		exec(0);
		clr();
		setop(0, 5, 0, 1, 1, 1, -32768);
		exec(1);
		clr();
		setop(0, 63, 12, 1, 4, 0, 0);
		exec(0);
		setop(0, 10, 0, 0, 0, 0, 0);
		setop(1, 63, 8, 1, 2, 1, 6);
		exec(0);
		do_scan();
		give_verdict();
	end
endmodule
bind operand_access operand_access_properties props (.clk_i, .rst_n_i, .start_i, .op_i, .src_digit_en_i,
	.src_code_i, .scan_i, .io_is_input_i, .bound_err_a_o, .bound_err_b_o, .done_o, .rejected_o, .scan_done_o,
	.out_words_o);
